// ---- src/wiper_chan.sv ----
// one channel of the host controller: drives select, step and direction
// assumes commands come from logic on core_clk
`include "wiper_ctl_defines.svh"
`default_nettype none
module wiper_chan #(
  parameter logic [`CNT_W-1:0] STORE_CYC = `CNT_W'(`T_STORE_CYC)
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // command
  input wire logic cmd_valid,
  input wire wiper_ctl_pkg::cmd_t cmd,
  output logic cmd_ready,
  // pins
  output wiper_ctl_pkg::pins_t pins
);
  wiper_ctl_pkg::state_t state_q, state_d;
  logic [`CNT_W-1:0] cnt_q, cnt_d;
  logic [4:0] left_q, left_d;
  logic up_q, up_d, store_q, store_d;
  wiper_ctl_pkg::pins_t pins_d;
  wire cnt_done = (cnt_q == '0);
  wire take = (state_q == wiper_ctl_pkg::ST_IDLE) && cnt_done && cmd_valid;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_done ? cnt_q : cnt_q - `CNT_W'(1);
    left_d = left_q;
    up_d = up_q;
    store_d = store_q;
    pins_d = pins;
    case (state_q)
      wiper_ctl_pkg::ST_IDLE: begin
        // a zero-step command without store has nothing to do on the pins
        if (take && (cmd.steps != 5'h00 || cmd.store)) begin
          up_d = cmd.up;
          left_d = cmd.steps;
          store_d = cmd.store;
          pins_d.sel_b = 1'b0;
          pins_d.up = cmd.up;
          cnt_d = `CNT_W'(`T_CI_CYC + `T_DI_CYC);
          state_d = wiper_ctl_pkg::ST_SEL;
        end
      end
      wiper_ctl_pkg::ST_SEL: begin
        if (cnt_done) begin
          if (left_q == 5'h00) begin
            state_d = wiper_ctl_pkg::ST_PARK;
            cnt_d = `CNT_W'(`T_IC_CYC);
          end else begin
            pins_d.step_b = 1'b0;
            left_d = left_q - 5'h01;
            cnt_d = `CNT_W'(`T_IL_CYC);
            state_d = wiper_ctl_pkg::ST_LOW;
          end
        end
      end
      wiper_ctl_pkg::ST_LOW: begin
        if (cnt_done) begin
          if (left_q == 5'h00 && !store_q) begin
            // last step of a no-store move: strobe stays low through deselect
            cnt_d = `CNT_W'(`T_IC_CYC);
            state_d = wiper_ctl_pkg::ST_PARK;
          end else begin
            pins_d.step_b = 1'b1;
            cnt_d = `CNT_W'(`T_IH_CYC);
            state_d = wiper_ctl_pkg::ST_HIGH;
          end
        end
      end
      wiper_ctl_pkg::ST_HIGH: begin
        if (cnt_done) begin
          if (left_q != 5'h00) begin
            pins_d.step_b = 1'b0;
            left_d = left_q - 5'h01;
            cnt_d = `CNT_W'(`T_IL_CYC);
            state_d = wiper_ctl_pkg::ST_LOW;
          end else begin
            // store exit: strobe stays high while select rises
            cnt_d = `CNT_W'(`T_IC_CYC);
            state_d = wiper_ctl_pkg::ST_PARK;
          end
        end
      end
      wiper_ctl_pkg::ST_PARK: begin
        if (cnt_done) begin
          pins_d.sel_b = 1'b1;
          cnt_d = store_q ? STORE_CYC : `CNT_W'(`T_CPH_CYC);
          state_d = wiper_ctl_pkg::ST_DESEL;
        end
      end
      wiper_ctl_pkg::ST_DESEL: begin
        pins_d.step_b = 1'b1;
        state_d = wiper_ctl_pkg::ST_IDLE;
      end
      default: state_d = wiper_ctl_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_q <= wiper_ctl_pkg::ST_IDLE;
      cnt_q <= STORE_CYC; // select held high after power-up
      left_q <= 5'h00;
      up_q <= 1'b0;
      store_q <= 1'b0;
      pins <= 3'b110;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      left_q <= left_d;
      up_q <= up_d;
      store_q <= store_d;
      pins <= pins_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) cmd_ready <= 1'b0;
    else cmd_ready <= (state_d == wiper_ctl_pkg::ST_IDLE) && (cnt_d == '0) && !take;
  end

  AST_STEP_SELECTED: assert property (@(posedge core_clk) disable iff (!rst_b)
    $fell(pins.step_b) |-> !pins.sel_b) else $error("step strobe fell while deselected");
  AST_NOSTORE_LOW: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(pins.sel_b) && !store_q |-> !pins.step_b) else $error("no-store exit strobe high");
  AST_STORE_HIGH: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(pins.sel_b) && store_q |-> pins.step_b) else $error("store exit strobe low");
  AST_DIR_STABLE: assert property (@(posedge core_clk) disable iff (!rst_b)
    $fell(pins.step_b) |-> $stable(pins.up)) else $error("direction moved at strobe edge");
  AST_STORE_GAP: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(pins.sel_b) && store_q |=> pins.sel_b [*8]) else $error("reselect too soon after store");
  AST_LOW_WIDTH: assert property (@(posedge core_clk) disable iff (!rst_b)
    $fell(pins.step_b) && !pins.sel_b |=> !pins.step_b [*8]) else $error("strobe low too short");
  AST_SEL_SETUP: assert property (@(posedge core_clk) disable iff (!rst_b)
    $fell(pins.sel_b) |=> pins.step_b [*8]) else $error("strobe too soon after select");
  AST_IDLE_DESEL: assert property (@(posedge core_clk) disable iff (!rst_b)
    state_q == wiper_ctl_pkg::ST_IDLE |-> pins.sel_b) else $error("select low while idle");
  COV_STORE: cover property (@(posedge core_clk) $rose(pins.sel_b) && store_q);
  COV_NOSTORE: cover property (@(posedge core_clk) $rose(pins.sel_b) && !store_q);
  COV_STEP_UP: cover property (@(posedge core_clk) $fell(pins.step_b) && pins.up);
endmodule
`default_nettype wire

// ---- src/wiper_ctl_defines.svh ----
// timing constants for the wiper host controller
// assumes a 100 MHz core clock
`ifndef WIPER_CTL_DEFINES_SVH
`define WIPER_CTL_DEFINES_SVH
`define CLK_PERIOD_NS 10
`define CH_COUNT 2
`define POS_W 5
`define POS_MAX 5'h1F
`define T_CI_NS 100
`define T_CI_CYC ((`T_CI_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_DI_NS 100
`define T_DI_CYC ((`T_DI_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_IL_US 1
`define T_IL_CYC ((`T_IL_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_IH_US 1
`define T_IH_CYC ((`T_IH_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_IC_US 1
`define T_IC_CYC ((`T_IC_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_CPH_NS 250
`define T_CPH_CYC ((`T_CPH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_STORE_MS 10
`define T_STORE_CYC ((`T_STORE_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 20
`endif

// ---- src/wiper_ctl_pkg.sv ----
// types shared by the wiper host controller
// assumes wiper_ctl_defines.svh is compiled alongside
`default_nettype none
package wiper_ctl_pkg;
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_SEL   = 7'h02,
    ST_DIR   = 7'h04,
    ST_LOW   = 7'h08,
    ST_HIGH  = 7'h10,
    ST_PARK  = 7'h20,
    ST_DESEL = 7'h40
  } state_t;
  // one command from the user side
  typedef struct packed {
    logic up;
    logic [4:0] steps;
    logic store;
  } cmd_t;
  // the three pins of one channel
  typedef struct packed {
    logic sel_b;
    logic step_b;
    logic up;
  } pins_t;
endpackage
`default_nettype wire

// ---- src/wiper_host.sv ----
// two-channel host controller for an up/down wiper device with store
`include "wiper_ctl_defines.svh"
`default_nettype none
module wiper_host #(
  parameter logic [`CNT_W-1:0] STORE_CYC = `CNT_W'(`T_STORE_CYC)
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // user commands, one per channel
  input wire logic [`CH_COUNT-1:0] cmd_valid,
  input wire wiper_ctl_pkg::cmd_t [`CH_COUNT-1:0] cmd,
  output logic [`CH_COUNT-1:0] cmd_ready,
  // device pins
  output wiper_ctl_pkg::pins_t [`CH_COUNT-1:0] pins
);
  genvar g;
  generate
    for (g = 0; g < `CH_COUNT; g++) begin : g_ch
      wiper_chan #(.STORE_CYC(STORE_CYC)) u_chan (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .cmd_valid(cmd_valid[g]),
        .cmd(cmd[g]),
        .cmd_ready(cmd_ready[g]),
        .pins(pins[g])
      );
    end
  endgenerate
endmodule
`default_nettype wire

// ---- verification/wiper_dev_model.sv ----
// behavioural model of the two-channel up/down wiper device with store and recall
// assumes its pins come straight from the host controller's registered outputs
`default_nettype none
module wiper_dev_model #(
  parameter logic [4:0] INIT_NV = 5'h0A
) (
  // pins from the host
  input wire wiper_ctl_pkg::pins_t [1:0] pins,
  // observed device state
  output logic [1:0][4:0] pos,
  output logic [1:0][4:0] nv,
  output wire logic [1:0][31:0] tap
);
  timeunit 1ns;
  timeprecision 1ns;
  for (genvar i = 0; i < 2; i++) begin : g_ch
    initial begin
      nv[i] = INIT_NV;
      pos[i] = INIT_NV;
    end
    assign tap[i] = 32'h1 << pos[i];
    always @(negedge pins[i].step_b) begin
      if (!pins[i].sel_b) begin
        if (pins[i].up && pos[i] != 5'h1F) pos[i] = pos[i] + 5'h01;
        else if (!pins[i].up && pos[i] != 5'h00) pos[i] = pos[i] - 5'h01;
      end
    end
    // leaving with step low keeps the count but not the store
    always @(posedge pins[i].sel_b) begin
      if (pins[i].step_b) nv[i] = pos[i];
    end
  end
endmodule
`default_nettype wire

// ---- verification/tb_wiper_host.sv ----
// self-checking bench for the two-channel wiper host controller
// assumes the device model observes the pins and store time is shortened to 40 cycles
`default_nettype none
module tb_wiper_host;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk;
  logic rst_b;
  logic [1:0] cmd_valid;
  wiper_ctl_pkg::cmd_t [1:0] cmd;
  wire logic [1:0] cmd_ready;
  wire wiper_ctl_pkg::pins_t [1:0] pins;
  wire logic [1:0][4:0] pos;
  wire logic [1:0][4:0] nv;
  wire logic [1:0][31:0] tap;
  int err_total = 0;
  int n_tests = 0;
  wiper_host #(.STORE_CYC(20'h28)) i_dut (.core_clk(core_clk), .rst_b(rst_b),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .pins(pins));
  wiper_dev_model i_dev (.pins(pins), .pos(pos), .nv(nv), .tap(tap));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // waits until every channel in m is idle, bounded
  task automatic wait_rdy(input logic [1:0] m, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while ((cmd_ready & m) !== m && n < lim);
    if ((cmd_ready & m) !== m) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, cmd_ready, m);
      stop_test();
    end
  endtask
  task automatic go(input logic [1:0] m, input wiper_ctl_pkg::cmd_t c0,
                    input wiper_ctl_pkg::cmd_t c1);
    wait_rdy(m, 200);
    cmd[0] <= c0;
    cmd[1] <= c1;
    cmd_valid <= m;
    @(posedge core_clk);
    cmd_valid <= 2'b00;
    wait_rdy(m, 10000);
  endtask
  task automatic t_powerup;
    check({31'h0, pins[0].sel_b}, 32'h1);
    check({31'h0, pins[1].sel_b}, 32'h1);
    check({27'h0, pos[0]}, 32'h0A);
    $display("test powerup done");
  endtask
  task automatic t_up_store;
    go(2'b01, '{1'b1, 5'h03, 1'b1}, '{1'b0, 5'h00, 1'b0});
    check({27'h0, pos[0]}, 32'h0D);
    check({27'h0, nv[0]}, 32'h0D);
    check(tap[0], 32'h2000);
    $display("test up_store done");
  endtask
  task automatic t_down_nostore;
    go(2'b01, '{1'b0, 5'h1F, 1'b0}, '{1'b0, 5'h00, 1'b0});
    check({27'h0, pos[0]}, 32'h00);
    check({27'h0, nv[0]}, 32'h0D);
    go(2'b01, '{1'b1, 5'h00, 1'b1}, '{1'b0, 5'h00, 1'b0});
    check({27'h0, nv[0]}, 32'h00);
    $display("test down_nostore done");
  endtask
  task automatic t_both;
    go(2'b11, '{1'b1, 5'h02, 1'b0}, '{1'b1, 5'h1F, 1'b1});
    check({27'h0, pos[0]}, 32'h02);
    check({27'h0, nv[0]}, 32'h00);
    check({27'h0, pos[1]}, 32'h1F);
    check({27'h0, nv[1]}, 32'h1F);
    go(2'b10, '{1'b0, 5'h00, 1'b0}, '{1'b0, 5'h01, 1'b0});
    check({27'h0, pos[1]}, 32'h1E);
    check({27'h0, nv[1]}, 32'h1F);
    go(2'b10, '{1'b0, 5'h00, 1'b0}, '{1'b1, 5'h00, 1'b0});
    check({27'h0, pos[1]}, 32'h1E);
    check({27'h0, nv[1]}, 32'h1F);
    $display("test both done");
  endtask
  initial begin
    rst_b <= 1'b0;
    cmd_valid <= 2'b00;
    cmd <= '0;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    t_powerup();
    t_up_store();
    t_down_nostore();
    t_both();
    stop_test();
  end
endmodule
`default_nettype wire
